// ---- common/gcr0_defines.vh ----
// Field layout, reset values and timing counts of the first global configuration register
`ifndef GCR0_DEFINES_VH
`define GCR0_DEFINES_VH

`define GCR0_ADDR_W          8
`define GCR0_OFFSET          8'h00
`define GCR0_RESET           32'h01000404
`define GCR0_WRITE_MASK      32'hFFFFCCFF

`define GCR0_DROP_BIT        31
`define GCR0_TRL_HI          30
`define GCR0_TRL_LO          27
`define GCR0_TRL_MAX         4'hC
`define GCR0_CR_EN_BIT       26
`define GCR0_PRIO_HI         25
`define GCR0_PRIO_LO         16
`define GCR0_PHY_HI          15
`define GCR0_PHY_LO          14
`define GCR0_HS_BIT          11
`define GCR0_OAM_BIT         10
`define GCR0_MSIZE_BIT       7
`define GCR0_FQ_HI           6
`define GCR0_FQ_LO           5
`define GCR0_COL_HI          4
`define GCR0_COL_LO          3
`define GCR0_CAS_HI          2
`define GCR0_CAS_LO          1
`define GCR0_SDRST_BIT       0

`define GCR0_PHY_MII         2'h0
`define GCR0_PHY_RMII        2'h1
`define GCR0_PHY_RSVD        2'h2
`define GCR0_PHY_SSMII       2'h3

`define GCR0_CLK_MHZ         200
`define GCR0_TICK_FINE_US    1
`define GCR0_TICK_COARSE_US  100
`define GCR0_FINE_CYCLES     (`GCR0_TICK_FINE_US * `GCR0_CLK_MHZ)
`define GCR0_COARSE_CYCLES   (`GCR0_TICK_COARSE_US * `GCR0_CLK_MHZ)

`endif

// ---- rtl/gcr0_tick_gen.v ----
// OAM timestamp tick divider and counter
`default_nettype none

module gcr0_tick_gen #(
	parameter integer FINE_CYCLES   = 200,
	parameter integer COARSE_CYCLES = 20000,
	parameter integer TS_W          = 32
) (
	input  wire            i_sys_clk,
	input  wire            i_rst,
	input  wire            i_ce,
	input  wire            i_coarse,
	output reg  [TS_W-1:0] o_timestamp
);
	reg  [15:0] div_reg;
	wire [15:0] limit = i_coarse ? COARSE_CYCLES[15:0] - 16'h0001
	                             : FINE_CYCLES[15:0] - 16'h0001;

	// Compare with >= so a resolution change mid-count cannot overrun
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_reg     <= 16'h0000;
			o_timestamp <= {TS_W{1'b0}};
		end else if (i_ce) begin
			if (div_reg >= limit) begin
				div_reg     <= 16'h0000;
				o_timestamp <= o_timestamp + {{(TS_W-1){1'b0}}, 1'b1};
			end else begin
				div_reg <= div_reg + 16'h0001;
			end
		end
	end
endmodule // gcr0_tick_gen

`default_nettype wire

// ---- rtl/gcr0_regs.v ----
// First global configuration register and the controls it drives
// How it works
// RULE1 - Drop-bad-checksum bit set discards received packets with wrong IP header sum
// RULE2 - Trailer length 0 to 12 attached to all packets; zero means none
// RULE3 - Clock recovery enable low keeps recovery block disabled; resets low
// RULE4 - Host avoids clock recovery region while the block is disabled
// RULE5 - Disabled clock recovery never asserts bus ready; access stays pending
// RULE6 - Receive FIFO wins arbitration when level exceeds threshold; resets 0x100
// RULE7 - Software should program threshold to maximum 0x3FF
// RULE8 - PHY select: 00 MII, 01 RMII, 11 SSMII, 10 reserved
// RULE9 - Software writes zero to reserved fields
// RULE10 - High-speed bit: port one only in E3/T3/STS-1, others disabled
// RULE11 - OAM timestamp ticks each 1 us or 100 us; bit resets to 1
// RULE12 - SDRAM clock select: 00 50 MHz, 01 75 MHz, others reserved
// RULE13 - Column width code gives 8, 9, 10 or 11 address bits
// RULE14 - Read latency codes 01..11 give 1..3 cycles; 00 reserved; resets 2
// RULE15 - SDRAM controller held in reset while active-low bit is zero
// RULE16 - Software configures SDRAM fields, then pulses reset bit low then high
// RULE17 - All fields read back last written value or reset value; reserved bits 13:12 and 9:8 are masked on write and always read zero
`default_nettype none
`include "gcr0_defines.vh"

module gcr0_regs #(
	parameter integer NUM_PORTS     = 8,
	parameter integer FIFO_LVL_W    = 10,
	parameter integer TS_W          = 32,
	parameter integer COARSE_CYCLES = `GCR0_COARSE_CYCLES
) (
	input  wire                  i_sys_clk,
	input  wire                  i_rst,
	input  wire                  i_ce,
	input  wire [`GCR0_ADDR_W-1:0] i_addr,
	input  wire                  i_cs,
	input  wire                  i_wr,
	input  wire                  i_rd,
	input  wire [31:0]           i_wdata,
	output reg  [31:0]           o_rdata,
	output reg                   o_rvalid,
	input  wire                  i_cr_access,
	input  wire                  i_cr_ready,
	output wire                  o_cr_ready,
	input  wire                  i_rx_pkt_valid,
	input  wire                  i_rx_l3_sum_bad,
	output reg                   o_rx_pkt_drop,
	output reg  [3:0]            o_trailer_len,
	output reg                   o_cr_enable,
	input  wire [FIFO_LVL_W-1:0] i_rx_fifo_level,
	output reg                   o_rx_fifo_priority,
	output reg                   o_phy_mii,
	output reg                   o_phy_rmii,
	output reg                   o_phy_ssmii,
	output reg  [NUM_PORTS-1:0]  o_port_enable,
	output reg                   o_port_high_speed,
	output wire [TS_W-1:0]       o_oam_timestamp,
	output reg                   o_sdram_clk_75,
	output reg                   o_sdram_clk_valid,
	output reg                   o_sdram_size_128,
	output reg  [3:0]            o_sdram_col_bits,
	output reg  [1:0]            o_sdram_read_lat,
	output reg                   o_sdram_ctrl_rst
);
	reg  [31:0] global_config_0_reg;
	reg  [31:0] global_config_0_next;
	wire        sel = i_cs && (i_addr == `GCR0_OFFSET);

	always @* begin
		global_config_0_next = global_config_0_reg;
		if (sel && i_wr) begin
			// Reserved bits forced low to keep them at zero
			global_config_0_next = i_wdata & `GCR0_WRITE_MASK; // see RULE17
		end
	end

	reg  [31:0] rdata_next;
	reg         rvalid_next;

	always @* begin
		rdata_next  = o_rdata;
		rvalid_next = 1'b0;
		if (i_cs && i_rd) begin
			// Unmapped reads answer zero so software never sees stale data
			if (sel) begin
				rdata_next  = global_config_0_reg; // see RULE17
				rvalid_next = 1'b1;
			end else begin
				rdata_next = 32'h00000000;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			global_config_0_reg <= `GCR0_RESET; // see RULE3, RULE6, RULE11, RULE14, RULE15
			o_rdata             <= 32'h00000000;
			o_rvalid            <= 1'b0;
		end else if (i_ce) begin
			global_config_0_reg <= global_config_0_next;
			o_rvalid            <= rvalid_next;
			o_rdata             <= rdata_next;
		end
	end

	// Ready never reaches the host while recovery is off; the cycle hangs
	assign o_cr_ready = i_cr_access && o_cr_enable && i_cr_ready; // see RULE5

	// Lengths above the legal top are clamped rather than passed on
	function [3:0] trailer_clamp;
		input [3:0] len;
		begin
			if (len > `GCR0_TRL_MAX) begin
				trailer_clamp = `GCR0_TRL_MAX;
			end else begin
				trailer_clamp = len;
			end
		end
	endfunction

	function phy_is;
		input [1:0] code;
		input [1:0] want;
		begin
			phy_is = (code == want);
		end
	endfunction

	function [3:0] col_bits;
		input [1:0] code;
		begin
			case (code)
				2'h0: col_bits = 4'h8;
				2'h1: col_bits = 4'h9;
				2'h2: col_bits = 4'hA;
				default: col_bits = 4'hB;
			endcase
		end
	endfunction

	// Returns {known rate, 75 MHz}; reserved codes give no valid clock
	function [1:0] sdram_clk_decode;
		input [1:0] code;
		begin
			case (code)
				2'h0: sdram_clk_decode = 2'h2;
				2'h1: sdram_clk_decode = 2'h3;
				default: sdram_clk_decode = 2'h0;
			endcase
		end
	endfunction

	wire [1:0] phy_sel = global_config_0_reg[`GCR0_PHY_HI:`GCR0_PHY_LO];
	wire [1:0] fq      = global_config_0_reg[`GCR0_FQ_HI:`GCR0_FQ_LO];
	wire [1:0] col     = global_config_0_reg[`GCR0_COL_HI:`GCR0_COL_LO];
	wire [3:0] trl     = global_config_0_reg[`GCR0_TRL_HI:`GCR0_TRL_LO];
	wire [FIFO_LVL_W-1:0] prio_thr =
		global_config_0_reg[`GCR0_PRIO_HI:`GCR0_PRIO_LO];
	wire hs = global_config_0_reg[`GCR0_HS_BIT];
	wire [1:0] clk_code = sdram_clk_decode(fq);

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rx_pkt_drop      <= 1'b0;
			o_trailer_len      <= 4'h0;
			o_cr_enable        <= 1'b0;
			o_rx_fifo_priority <= 1'b0;
			o_phy_mii          <= 1'b1;
			o_phy_rmii         <= 1'b0;
			o_phy_ssmii        <= 1'b0;
			o_port_enable      <= {NUM_PORTS{1'b1}};
			o_port_high_speed  <= 1'b0;
			o_sdram_clk_75     <= 1'b0;
			o_sdram_clk_valid  <= 1'b1;
			o_sdram_size_128   <= 1'b0;
			o_sdram_col_bits   <= 4'h8;
			o_sdram_read_lat   <= 2'h2;
			o_sdram_ctrl_rst   <= 1'b1;
		end else if (i_ce) begin
			o_rx_pkt_drop <= i_rx_pkt_valid && i_rx_l3_sum_bad &&
				global_config_0_reg[`GCR0_DROP_BIT]; // see RULE1
			// Out-of-range lengths are clamped to the largest legal trailer
			o_trailer_len <= trailer_clamp(trl); // see RULE2
			o_cr_enable   <= global_config_0_reg[`GCR0_CR_EN_BIT]; // see RULE3
			o_rx_fifo_priority <= (i_rx_fifo_level > prio_thr); // see RULE6
			o_phy_mii     <= phy_is(phy_sel, `GCR0_PHY_MII); // see RULE8
			o_phy_rmii    <= phy_is(phy_sel, `GCR0_PHY_RMII); // see RULE8
			o_phy_ssmii   <= phy_is(phy_sel, `GCR0_PHY_SSMII); // see RULE8
			o_port_high_speed <= hs; // see RULE10
			o_port_enable <= hs ? {{(NUM_PORTS-1){1'b0}}, 1'b1}
			                    : {NUM_PORTS{1'b1}}; // see RULE10
			o_sdram_clk_75    <= clk_code[0]; // see RULE12
			o_sdram_clk_valid <= clk_code[1]; // see RULE12
			o_sdram_size_128  <= global_config_0_reg[`GCR0_MSIZE_BIT];
			o_sdram_col_bits  <= col_bits(col); // see RULE13
			o_sdram_read_lat  <=
				global_config_0_reg[`GCR0_CAS_HI:`GCR0_CAS_LO]; // see RULE14
			o_sdram_ctrl_rst  <= ~global_config_0_reg[`GCR0_SDRST_BIT]; // see RULE15
		end
	end

	gcr0_tick_gen #(
		.FINE_CYCLES   (`GCR0_FINE_CYCLES),
		.COARSE_CYCLES (COARSE_CYCLES),
		.TS_W          (TS_W)
	) u_tick (
		.i_sys_clk   (i_sys_clk),
		.i_rst       (i_rst),
		.i_ce        (i_ce),
		.i_coarse    (global_config_0_reg[`GCR0_OAM_BIT]), // see RULE11
		.o_timestamp (o_oam_timestamp)
	);
endmodule // gcr0_regs

`default_nettype wire

// ---- verification/gcr0_host.sv ----
// Host processor model driving the register bus
`default_nettype none
`include "gcr0_defines.vh"
module gcr0_host (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_rvalid,
	output var  logic        i_cs,
	output var  logic        i_wr,
	output var  logic        i_rd,
	output var  logic [7:0]  i_addr,
	output var  logic [31:0] i_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {i_cs, i_wr, i_rd, i_addr, i_wdata} = '0;
	// Any register bus address given is reached, never the clock recovery space
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge i_sys_clk);
		{i_cs, i_wr, i_addr, i_wdata} = {2'b11, a, d & `GCR0_WRITE_MASK};
		@(negedge i_sys_clk);
		{i_cs, i_wr, i_wdata} = {2'b00, ~d};
	endtask
	task rd(input logic [7:0] a, output logic [32:0] q);
		@(negedge i_sys_clk);
		{i_cs, i_rd, i_addr} = {2'b11, a};
		@(negedge i_sys_clk);
		{i_cs, i_rd} = 2'b00;
		q = {o_rvalid, o_rdata};
	endtask
endmodule // gcr0_host
`default_nettype wire

// ---- verification/gcr0_asserts.sv ----
// Port-level checks of the configuration register
`default_nettype none
module gcr0_asserts (
	input wire logic i_sys_clk, i_rst, i_ce, i_cs, i_wr, i_rd, i_cr_access, i_cr_ready,
	input wire logic o_cr_ready, o_cr_enable, i_rx_pkt_valid, i_rx_l3_sum_bad,
	input wire logic o_rx_pkt_drop, o_rvalid, o_rx_fifo_priority, o_sdram_ctrl_rst,
	input wire logic [7:0] i_addr, o_port_enable,
	input wire logic [31:0] i_wdata, o_oam_timestamp,
	input wire logic [9:0] i_rx_fifo_level,
	input wire logic [3:0] o_trailer_len
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_wr0; i_ce && i_cs && i_wr && i_addr == 8'h00; endsequence
	sequence s_cfg; s_wr0 ##1 i_ce; endsequence
	a_drop_cause: assert property (o_rx_pkt_drop |-> $past(i_rx_pkt_valid && i_rx_l3_sum_bad))
		else $error("drop without a bad packet");
	a_cr_gate: assert property (o_cr_ready == (i_cr_access && i_cr_ready && o_cr_enable))
		else $error("recovery ready while disabled");
	a_trailer_clamp: assert property (s_cfg |=> o_trailer_len ==
		($past(i_wdata[30:27], 2) > 4'hC ? 4'hC : $past(i_wdata[30:27], 2))) else $error("trailer");
	a_prio_thresh: assert property (s_cfg |=> o_rx_fifo_priority ==
		($past(i_rx_fifo_level) > $past(i_wdata[25:16], 2))) else $error("fifo priority");
	a_port_mode: assert property (s_cfg |=> o_port_enable ==
		($past(i_wdata[11], 2) ? 8'h01 : 8'hFF)) else $error("port enables");
	a_sdram_hold: assert property (s_cfg |=> o_sdram_ctrl_rst == !$past(i_wdata[0], 2))
		else $error("sdram reset");
	a_ts_step: assert property (!$past(i_rst) && $changed(o_oam_timestamp) |->
		o_oam_timestamp == $past(o_oam_timestamp) + 32'h1) else $error("timestamp jump");
	a_read_valid: assert property (i_ce && i_cs && i_rd |=> o_rvalid == $past(i_addr == 8'h00))
		else $error("read valid");
endmodule // gcr0_asserts
bind gcr0_regs gcr0_asserts chk_i (.*);
`default_nettype wire

// ---- verification/test_global_config_register_zero.sv ----
// Self-checking bench for the first global configuration register
`default_nettype none
module test_global_config_register_zero;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CRS = 400;
	logic i_sys_clk = 0, i_rst = 1, i_cs, i_wr, i_rd, i_cr_access = 0, i_cr_ready = 1;
	logic i_rx_pkt_valid = 0, i_rx_l3_sum_bad = 1, o_rvalid, o_cr_ready, o_rx_pkt_drop;
	logic o_cr_enable, o_rx_fifo_priority, o_phy_mii, o_phy_rmii, o_phy_ssmii, o_port_high_speed;
	logic o_sdram_clk_75, o_sdram_clk_valid, o_sdram_size_128, o_sdram_ctrl_rst;
	logic [1:0]  o_sdram_read_lat;
	logic [3:0]  o_trailer_len, o_sdram_col_bits;
	logic [7:0]  i_addr, o_port_enable;
	logic [9:0]  i_rx_fifo_level = 10'h000;
	logic [31:0] i_wdata, o_rdata, o_oam_timestamp, w, t0;
	logic [32:0] q;
	int n_errors = 0, total_checks = 0, cyc = 0;
	wire logic i_ce = 1'b1;
	wire logic [15:0] cfv = {o_trailer_len, o_phy_mii, o_phy_rmii, o_phy_ssmii, o_port_enable,
		o_port_high_speed};
	wire logic [10:0] sdv = {o_sdram_clk_75, o_sdram_clk_valid, o_sdram_size_128,
		o_sdram_col_bits, o_sdram_read_lat, o_sdram_ctrl_rst, o_cr_enable};
	gcr0_regs #(.COARSE_CYCLES(CRS)) dut (.*);
	gcr0_host host (.*);
	always #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (++cyc == 6000) begin
		n_errors++;
		stop_test;
	end
	task chk(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task t_fields;
		host.rd(8'h00, q);
		chk(q, 33'h101000404);
		chk({o_cr_enable, o_port_enable, o_sdram_ctrl_rst, o_sdram_read_lat}, 12'h7FE);
		for (int i = 0; i < 4; i++) begin
			// Last iterations push the trailer past its top value
			w = {1'b0, 4'(11 + i), i[0], 10'(i), i[1:0], 2'b0, i[0], i[1], 2'b0, i[0], i[1:0],
				i[1:0], i[1:0], ~i[0]};
			host.wr(8'h00, w);
			host.rd(8'h00, q);
			chk(q, {1'b1, w});
			q = {4'(i > 1 ? 12 : 11 + i), i == 0, i == 1, i == 3, i[0] ? 8'h01 : 8'hFF, i[0]};
			chk(cfv, q);
			q = {i == 1, i < 2, i[0], 4'(8 + i), i[1:0], i[0], i[0]};
			chk(sdv, q);
		end
		host.wr(8'h04, 32'hFFFFFFFF);
		host.rd(8'h04, q);
		chk(q, 33'h0);
		host.rd(8'h00, q);
		chk(q, {1'b1, w});
		$display("fields done");
	endtask
	task t_drop;
		for (int b = 0; b < 3; b++) begin
			host.wr(8'h00, {b > 0, 31'h1});
			@(negedge i_sys_clk);
			{i_rx_pkt_valid, i_rx_l3_sum_bad} = {1'b1, b != 1};
			@(negedge i_sys_clk);
			chk(o_rx_pkt_drop, 33'(b == 2));
			i_rx_pkt_valid = 0;
		end
		$display("drop done");
	endtask
	task t_prio_cr;
		host.wr(8'h00, 32'h00FF0001);
		i_cr_access = 1;
		for (int k = 0; k < 2; k++) begin
			i_rx_fifo_level = 10'h0FF + 10'(k);
			repeat (2) @(negedge i_sys_clk);
			chk(o_rx_fifo_priority, 33'(k == 1));
			chk(o_cr_ready, 0);
		end
		host.wr(8'h00, 32'h03FF0001);
		i_rx_fifo_level = 10'h3FF;
		repeat (2) @(negedge i_sys_clk);
		chk(o_rx_fifo_priority, 0);
		host.wr(8'h00, 32'h04000001);
		repeat (2) @(negedge i_sys_clk);
		chk(o_cr_ready, 1);
		i_cr_access = 0;
		$display("priority and recovery done");
	endtask
	task t_ts;
		for (int m = 0; m < 2; m++) begin
			host.wr(8'h00, {21'h0, m[0], 10'h001});
			repeat (CRS) @(negedge i_sys_clk);
			t0 = o_oam_timestamp;
			repeat (m ? CRS : 200) @(negedge i_sys_clk);
			chk(o_oam_timestamp - t0, 1);
		end
		$display("timestamp done");
	endtask
	task stop_test;
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge i_sys_clk);
		i_rst = 0;
		t_fields;
		t_drop;
		t_prio_cr;
		t_ts;
		stop_test;
	end
endmodule // test_global_config_register_zero
`default_nettype wire
